// ==== hdl/dac_front_pkg.sv ====
// Purpose: shared constants for the serial dac input front end
// Assumes: 12-bit straight binary words, msb first
// Notes:   no software registers; all control is by pins
package dac_front_pkg;
    localparam int          CODE_W      = 12;
    localparam logic [11:0] CLEAR_CODE  = 12'h000;
    localparam logic [11:0] SHIFT_RESET = 12'h000;
    // idle pin levels after reset: link clock low, data and strobes high
    localparam logic [4:0]  PIN_IDLE    = 5'h0F;
    localparam int          MV_PER_CODE = 1;
    localparam int          SYNC_STAGES = 2;
endpackage : dac_front_pkg

// ==== hdl/pin_sync.sv ====
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clock_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    // pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] pins_i,
    input  wire logic [WIDTH-1:0] reset_val_i,
    output logic      [WIDTH-1:0] levels_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb
    begin
        state_next.meta   = pins_i;
        state_next.stable = state_reg.meta;
    end

    // reset value arrives on a port but is loaded synchronously, never asynchronously
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg.meta   <= reset_val_i;
            state_reg.stable <= reset_val_i;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign levels_o = state_reg.stable;
endmodule : pin_sync
`default_nettype wire

// ==== hdl/serial_dac_input_latch.sv ====
// Purpose: digital front end of a serial-input voltage-output dac
// Assumes: pins are sampled by clock_i (10 MHz), link clock much slower
// Notes:   edges of the pins are found after two-flop synchronisation
// Contract
// - shift data on clock rise while selected
// - select rise with clock low also shifts
// - load low makes holding register transparent
// - shifting under low load updates output
// - clear low forces holding register to zero
// - clear gives zero code, 1mV per step
// - straight binary words, msb first
// - after clear, zero holds until load low
`timescale 1ns/10ps
`default_nettype none
module serial_dac_input_latch (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // serial link pins from the host
    input  wire logic        serial_clock_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        serial_data_in_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        clear_n_i,
    // converter side
    output logic      [11:0] analog_out_o,
    output logic      [11:0] shift_word_o
);
    typedef struct packed {
        logic        sclk_d;
        logic        cs_n_d;
        logic        ld_n_d;
        logic [11:0] shift_word;
        logic [11:0] hold_word;
    } front_state_t;

    front_state_t state_reg;
    front_state_t state_next;

    logic [4:0] pins_s;
    logic       sclk_s;
    logic       cs_n_s;
    logic       sdi_s;
    logic       ld_n_s;
    logic       clr_n_s;
    logic       advance;
    logic       ld_fall;

    // idle pin levels: clock low, data high, strobes deasserted
    pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .pins_i      ({serial_clock_i, chip_select_n_i, serial_data_in_i,
                       load_strobe_n_i, clear_n_i}),
        .reset_val_i (dac_front_pkg::PIN_IDLE),
        .levels_o    (pins_s)
    );

    assign {sclk_s, cs_n_s, sdi_s, ld_n_s, clr_n_s} = pins_s;

    // either input may act as the clock: rise of one while the other is in its low state
    // a low load does not stop shifting; the open latch then shows every new bit
    assign advance = clr_n_s &&
                     ((!cs_n_s && sclk_s && !state_reg.sclk_d)
                      || (!sclk_s && cs_n_s && !state_reg.cs_n_d));
    assign ld_fall = state_reg.ld_n_d && !ld_n_s;

    always_comb
    begin
        state_next        = state_reg;
        state_next.sclk_d = sclk_s;
        state_next.cs_n_d = cs_n_s;
        state_next.ld_n_d = ld_n_s;
        if (advance)
        begin
            state_next.shift_word = {state_reg.shift_word[10:0], sdi_s};
        end
        // clear dominates; shift register untouched by clear
        if (!clr_n_s)
        begin
            state_next.hold_word = dac_front_pkg::CLEAR_CODE;
        end
        else if (!ld_n_s)
        begin
            // transparency tracks the word as it will stand after this edge
            state_next.hold_word = state_next.shift_word;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg.sclk_d     <= 1'b0;
            state_reg.cs_n_d     <= 1'b1;
            state_reg.ld_n_d     <= 1'b1;
            state_reg.shift_word <= dac_front_pkg::SHIFT_RESET;
            state_reg.hold_word  <= dac_front_pkg::CLEAR_CODE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // output code is millivolts directly at one step per code
    assign analog_out_o = state_reg.hold_word;
    assign shift_word_o = state_reg.shift_word;

    property p_shift_rise;
        @(posedge clock_i) disable iff (srst_i)
        advance |=> state_reg.shift_word == {$past(state_reg.shift_word[10:0]), $past(sdi_s)};
    endproperty
    a_shift_rise: assert property (p_shift_rise)
        else $error("shift register did not advance on clock rise");

    property p_cs_rise;
        @(posedge clock_i) disable iff (srst_i)
        (clr_n_s && !sclk_s && cs_n_s && !state_reg.cs_n_d)
            |=> state_reg.shift_word[0] == $past(sdi_s);
    endproperty
    a_cs_rise: assert property (p_cs_rise)
        else $error("select rise did not advance shift register");

    property p_hold_still;
        @(posedge clock_i) disable iff (srst_i)
        (!advance && !(clr_n_s && !ld_n_s) && clr_n_s)
            |=> $stable(state_reg.shift_word) && $stable(state_reg.hold_word);
    endproperty
    a_hold_still: assert property (p_hold_still)
        else $error("registers changed without cause");

    property p_transparent;
        @(posedge clock_i) disable iff (srst_i)
        (clr_n_s && !ld_n_s) |=> analog_out_o == shift_word_o;
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("holding register not transparent under load");

    // a shift on the same edge is covered by the transparency check instead
    sequence s_load_fall;
        clr_n_s && ld_fall && !advance;
    endsequence
    property p_load_copy;
        @(posedge clock_i) disable iff (srst_i)
        s_load_fall |=> analog_out_o == shift_word_o && shift_word_o == $past(shift_word_o);
    endproperty
    a_load_copy: assert property (p_load_copy)
        else $error("load edge did not copy shift register");

    sequence s_shift_under_load;
        (clr_n_s && !ld_n_s) ##1 (clr_n_s && !ld_n_s && advance);
    endsequence
    property p_follow;
        @(posedge clock_i) disable iff (srst_i)
        s_shift_under_load |=> analog_out_o == {$past(analog_out_o[10:0]), $past(sdi_s)};
    endproperty
    a_follow: assert property (p_follow)
        else $error("output did not follow shifting under load");

    property p_clear;
        @(posedge clock_i) disable iff (srst_i)
        !clr_n_s |=> analog_out_o == dac_front_pkg::CLEAR_CODE
            && shift_word_o == $past(shift_word_o);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero holding register");

    sequence s_clear_release_idle;
        !clr_n_s ##1 (clr_n_s && ld_n_s);
    endsequence
    property p_clear_hold;
        @(posedge clock_i) disable iff (srst_i)
        s_clear_release_idle |=> analog_out_o == dac_front_pkg::CLEAR_CODE;
    endproperty
    a_clear_hold: assert property (p_clear_hold)
        else $error("zero code lost after clear release");

    // built from the pins directly, not from advance
    property p_clock_rise_bit;
        @(posedge clock_i) disable iff (srst_i)
        (clr_n_s && !cs_n_s && sclk_s && !state_reg.sclk_d)
            |=> state_reg.shift_word[0] == $past(sdi_s);
    endproperty
    a_clock_rise_bit: assert property (p_clock_rise_bit)
        else $error("clock rise did not take the data bit");

    property p_no_stray_shift;
        @(posedge clock_i) disable iff (srst_i)
        !advance |=> shift_word_o == $past(shift_word_o);
    endproperty
    a_no_stray_shift: assert property (p_no_stray_shift)
        else $error("shift register moved without a link edge");

    property p_cs_high_quiet;
        @(posedge clock_i) disable iff (srst_i)
        (cs_n_s && state_reg.cs_n_d)
            |=> shift_word_o == $past(shift_word_o);
    endproperty
    a_cs_high_quiet: assert property (p_cs_high_quiet)
        else $error("shift register moved while deselected");

    sequence s_release_under_load;
        !clr_n_s ##1 (clr_n_s && !ld_n_s);
    endsequence
    property p_release_load;
        @(posedge clock_i) disable iff (srst_i)
        s_release_under_load |=> analog_out_o == shift_word_o;
    endproperty
    a_release_load: assert property (p_release_load)
        else $error("clear release under load did not take the shift word");

    property p_clear_over_load;
        @(posedge clock_i) disable iff (srst_i)
        (!clr_n_s && !ld_n_s) |=> analog_out_o == dac_front_pkg::CLEAR_CODE;
    endproperty
    a_clear_over_load: assert property (p_clear_over_load)
        else $error("load overrode clear");
endmodule : serial_dac_input_latch
`default_nettype wire

// ==== tb/host_serial_model.sv ====
// Purpose: host model driving the serial pins of the dac front end
// Assumes: pins move just after clock_i rises; link clock period 800 ns
// Notes:   link clock stands low outside frames; released data is inverted
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
    // system clock
    input  wire logic clock_i,
    // pins to the device
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    output logic      ld_n_o,
    output logic      clr_n_o
);
    initial
    begin
        sclk_o  = 1'b0;
        cs_n_o  = 1'b1;
        sdi_o   = 1'b0;
        ld_n_o  = 1'b1;
        clr_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick
    // n bits, msb first a full update is twelve bits
    task automatic send_bits(input logic [11:0] w, input int n);
        cs_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi_o <= w[i];
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
            // deselect with the clock high: a select rise with it low is a shift
            if (i == 0)
            begin
                cs_n_o <= 1'b1;
                tick(4);
            end
            sclk_o <= 1'b0;
        end
        sdi_o <= ~w[0];
        tick(4);
    endtask : send_bits
    // select rise with the link clock low counts as one clock
    task automatic cs_shift(input logic d);
        cs_n_o <= 1'b0;
        sdi_o  <= d;
        tick(4);
        cs_n_o <= 1'b1;
        tick(4);
        sdi_o <= ~d;
    endtask : cs_shift
    // select stays high while load or clear move
    task automatic pins(input logic ld_n, input logic clr_n);
        ld_n_o  <= ld_n;
        clr_n_o <= clr_n;
        tick(4);
    endtask : pins
endmodule : host_serial_model
`default_nettype wire

// ==== tb/serial_dac_input_latch_test.sv ====
// Purpose: self-checking bench for the serial dac input latch
// Assumes: host model drives the pins; 10 MHz system clock
// Notes:   waits of 4 cycles exceed the 3-edge pin latency
`timescale 1ns/10ps
`default_nettype none
module serial_dac_input_latch_test;
    logic        clock_i = 1'b0;
    logic        srst_i  = 1'b1;
    logic        sclk, cs_n, serial_data_in, ld_n, clr_n;
    logic [11:0] analog_out, shift_word;
    int          errors, n_compared;
    logic [11:0] words [4] = '{12'hFFF, 12'h801, 12'h800, 12'h7FF};
    int          mv    [4] = '{4095, 2049, 2048, 2047};
    always #50 clock_i = ~clock_i;
    host_serial_model host (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(serial_data_in), .ld_n_o(ld_n), .clr_n_o(clr_n));
    serial_dac_input_latch uut (.clock_i(clock_i), .srst_i(srst_i),
        .serial_clock_i(sclk), .chip_select_n_i(cs_n), .serial_data_in_i(serial_data_in),
        .load_strobe_n_i(ld_n), .clear_n_i(clr_n), .analog_out_o(analog_out),
        .shift_word_o(shift_word));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // a whole run needs about 624 cycles
    initial
    begin
        repeat (5000) @(posedge clock_i);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        host.tick(2);
        check(analog_out, 12'h000);
        check(shift_word, 12'h000);
        for (int r = 0; r < 4; r++)
        begin
            host.send_bits(words[r], 12);
            check(shift_word, words[r]);
            check(analog_out, r == 0 ? 12'h000 : words[r - 1]);
            host.pins(1'b0, 1'b1);
            host.pins(1'b1, 1'b1);
            check(analog_out, 12'(mv[r] / dac_front_pkg::MV_PER_CODE));
            check(shift_word, words[r]);
        end
        host.cs_shift(1'b0);
        check(shift_word, 12'hFFE);
        // a bit shifted under a low load shows on the output at once
        host.pins(1'b0, 1'b1);
        check(analog_out, 12'hFFE);
        host.send_bits(12'h001, 1);
        check(shift_word, 12'hFFD);
        check(analog_out, 12'hFFD);
        host.pins(1'b1, 1'b0);
        check(analog_out, dac_front_pkg::CLEAR_CODE);
        check(shift_word, 12'hFFD);
        host.pins(1'b1, 1'b1);
        check(analog_out, 12'h000);
        host.pins(1'b0, 1'b0);
        check(analog_out, 12'h000);
        host.pins(1'b0, 1'b1);
        check(analog_out, 12'hFFD);
        host.pins(1'b1, 1'b1);
        // reset mid-run clears both words; the link works again afterwards
        srst_i <= 1'b1;
        host.tick(6);
        srst_i <= 1'b0;
        host.tick(2);
        check(analog_out, dac_front_pkg::CLEAR_CODE);
        check(shift_word, dac_front_pkg::SHIFT_RESET);
        host.send_bits(12'hA5C, 12);
        check(shift_word, 12'hA5C);
        host.pins(1'b0, 1'b1);
        host.pins(1'b1, 1'b1);
        check(analog_out, 12'hA5C);
        complete_run();
    end
endmodule : serial_dac_input_latch_test
`default_nettype wire
